// >>> common/dhp_pkg.sv
package dhp_pkg;
	// transfer modes
	typedef enum logic [1:0] {
		DHP_MODE_HANDSHAKE = 2'h0,
		DHP_MODE_EXT_HS    = 2'h1,
		DHP_MODE_PACED     = 2'h2,
		DHP_MODE_OFF       = 2'h3
	} dhp_mode_t;

	// register offsets
	localparam logic [3:0] CTRL_OFF   = 4'h0;
	localparam logic [3:0] WAIT_OFF   = 4'h1;
	localparam logic [3:0] ADDR_OFF   = 4'h2;
	localparam logic [3:0] STATUS_OFF = 4'h3;
	localparam logic [3:0] DATA_OFF   = 4'h4;
	localparam logic [3:0] COUNT_OFF  = 4'h5;

	// ctrl fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DIR_BIT  = 2;
	localparam int CTRL_SEL_LSB  = 4;
	localparam int CTRL_INC_BIT  = 6;
	// wait fields
	localparam int WAIT_WS_LSB   = 0;
	localparam int WAIT_HOLD_BIT = 4;
	localparam int WAIT_IDLE_BIT = 5;

	localparam logic [31:0] CTRL_RST = 32'h0000_0003;
	localparam logic [31:0] WAIT_RST = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;

	// timing: clock period and minimum grant-high time
	localparam int CLK_PERIOD_NS = 50;
	localparam int GRANT_HIGH_NS = 6;
	localparam int GRANT_HIGH_CYC =
		((GRANT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((GRANT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam int DATA_W    = 32;
	localparam int FIFO_DEPTH = 32;

	// memory-side strobes travel together
	typedef struct packed {
		logic        rd_n;
		logic        wr_n;
		logic        sw_n;
		logic        page;
		logic [3:0]  ms_n;
		logic        dma_grant_n_n;
	} dhp_strobe_t;

	localparam dhp_strobe_t STROBE_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, sw_n: 1'b1,
		page: 1'b0, ms_n: 4'hf, dma_grant_n_n: 1'b1};
endpackage

// >>> hw/dhp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	wire              push;
	wire              pop;

	// handshake terms
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH)); // full at exactly DEPTH words
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rp_q];
	assign level     = cnt_q;

	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop)  rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// >>> hw/dhp_port.sv
// Notes on behaviour
// R1 - a transfer in any mode starts only after a recognised low request.
// R2 - in handshake mode the low grant is what outside logic uses to latch or drive data.
// R3 - external handshake drives address, strobes, sync write, page, selects and grant.
// R4 - paced master drives address, strobes and selects but never the grant.
// R5 - request held low holds off write completion until it returns high.
// R6 - request held low during a read prolongs the access one clock per extra cycle.
// R7 - request is sampled on the clock; a late edge is recognised in a later cycle.
// R8 - each programmed wait state adds one clock to the grant-low part.
// R9 - address hold or bus idle adds one clock between grant high and next access.
// R10 - on writes the write strobe falls with the grant and rises one clock before it.
// R11 - on reads the read strobe falls with the grant and rises no later than it.
// R12 - the grant is a registered output changing only at clock edges.
// R13 - exactly one transfer per recognised request, grant high before the next.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dhp_port #(
	parameter int DATA_W = dhp_pkg::DATA_W,
	parameter int DEPTH  = dhp_pkg::FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	// register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// external pins
	input  wire logic              dma_request_n,
	output logic                   dma_grant_n,
	output logic                   rd_n,
	output logic                   wr_n,
	output logic                   sync_write_select_n,
	output logic                   page,
	output logic [3:0]             memory_select_n,
	output logic                   ack,
	output logic [31:0]            addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe
);
	typedef enum logic [2:0] {
		DHP_IDLE, DHP_ACCESS, DHP_WAITS, DHP_STRETCH, DHP_LAST, DHP_HOLD, DHP_GAP
	} dhp_state_t;

	dhp_state_t       st_q;
	dhp_state_t       st_d;
	logic [31:0]      ctrl_q;
	logic [31:0]      wait_q;
	logic [31:0]      addr_q;
	logic [31:0]      count_q;
	logic [3:0]       ws_q;
	logic             req_s1_q;
	logic             req_s2_q;
	logic             req_armed_q;
	logic             err_q;
	logic             rvalid_q;
	logic [31:0]      rdata_q;
	logic [DATA_W-1:0] dout_q;
	logic             oe_q;
	logic             ack_q;
	dhp_pkg::dhp_strobe_t stb_q;
	dhp_pkg::dhp_strobe_t stb_d;

	// fifo wiring
	logic [DATA_W-1:0] fin_data;
	logic              fin_valid;
	logic              fin_ready;
	logic [DATA_W-1:0] fout_data;
	logic              fout_valid;
	logic              fout_ready;
	logic [$clog2(DEPTH):0] flevel;

	// decoded configuration
	wire dhp_pkg::dhp_mode_t mode = dhp_pkg::dhp_mode_t'(ctrl_q[dhp_pkg::CTRL_MODE_LSB +: 2]);
	wire        is_write  = ctrl_q[dhp_pkg::CTRL_DIR_BIT];
	wire [1:0]  sel       = ctrl_q[dhp_pkg::CTRL_SEL_LSB +: 2];
	wire        addr_inc  = ctrl_q[dhp_pkg::CTRL_INC_BIT];
	wire [3:0]  ws_cfg    = wait_q[dhp_pkg::WAIT_WS_LSB +: 4];
	wire        hold_cfg  = wait_q[dhp_pkg::WAIT_HOLD_BIT] | wait_q[dhp_pkg::WAIT_IDLE_BIT];
	wire        enabled   = (mode != dhp_pkg::DHP_MODE_OFF);
	wire        paced     = (mode == dhp_pkg::DHP_MODE_PACED);
	wire        ext_hs    = (mode == dhp_pkg::DHP_MODE_EXT_HS);
	wire        req_low   = ~req_s2_q;
	// R1 start condition
	wire        start     = enabled && req_low && req_armed_q
		&& (is_write ? fout_valid : fin_ready);
	wire        hold_need = req_low;
	wire        last_out  = (st_q == DHP_LAST);

	// register decode
	wire sel_ctrl  = (reg_addr == dhp_pkg::CTRL_OFF);
	wire sel_wait  = (reg_addr == dhp_pkg::WAIT_OFF);
	wire sel_addr  = (reg_addr == dhp_pkg::ADDR_OFF);
	wire sel_stat  = (reg_addr == dhp_pkg::STATUS_OFF);
	wire sel_data  = (reg_addr == dhp_pkg::DATA_OFF);
	wire sel_count = (reg_addr == dhp_pkg::COUNT_OFF);
	wire [31:0] status_w = {16'h0000, 2'h0, flevel[5:0] & 6'h3f, 3'h0,
		err_q, ~dma_grant_n, req_low, fout_valid, fin_ready};

	// data path: write transfers drain the fifo, reads fill it
	assign fin_data   = reg_wr && sel_data ? reg_wdata[DATA_W-1:0] : data_in;
	assign fin_valid  = (reg_wr && sel_data && is_write) || (!is_write && last_out);
	assign fout_ready = (reg_rd && sel_data && !is_write) || (is_write && st_q == DHP_IDLE && start);

	dhp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (fin_data),
		.in_valid  (fin_valid),
		.in_ready  (fin_ready),
		.out_data  (fout_data),
		.out_valid (fout_valid),
		.out_ready (fout_ready),
		.level     (flevel)
	);

	// R7 request synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_q <= 1'b1;
			req_s2_q <= 1'b1;
		end else begin
			req_s1_q <= dma_request_n;
			req_s2_q <= req_s1_q;
		end
	end

	// next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			DHP_IDLE: begin
				if (start) st_d = DHP_ACCESS;
			end
			DHP_ACCESS: begin
				// R8 wait states lengthen grant low
				if (ws_cfg != 4'h0) st_d = DHP_WAITS;
				else if (hold_need) st_d = DHP_STRETCH;
				else st_d = DHP_LAST;
			end
			DHP_WAITS: begin
				if (ws_q == 4'h1) st_d = hold_need ? DHP_STRETCH : DHP_LAST;
			end
			DHP_STRETCH: begin
				// R5 R6 request low stretches the access
				if (!hold_need) st_d = DHP_LAST;
			end
			DHP_LAST: begin
				st_d = DHP_HOLD;
			end
			DHP_HOLD: begin
				// R9 extra clock for address hold or idle
				st_d = hold_cfg ? DHP_GAP : DHP_IDLE;
			end
			DHP_GAP: begin
				st_d = DHP_IDLE;
			end
			default: st_d = DHP_IDLE;
		endcase
	end

	// strobe pattern per state and mode
	always_comb begin
		stb_d = dhp_pkg::STROBE_IDLE;
		if (st_d == DHP_ACCESS || st_d == DHP_WAITS || st_d == DHP_STRETCH
			|| st_d == DHP_LAST) begin
			// R2 R3 R4 grant only outside paced master
			stb_d.dma_grant_n_n = paced;
			if (!(mode == dhp_pkg::DHP_MODE_HANDSHAKE)) begin
				stb_d.ms_n     = ~(4'h1 << sel);
				stb_d.page     = ext_hs;
				stb_d.sw_n     = ~(ext_hs && is_write);
				// R11 read strobe ends with grant
				stb_d.rd_n     = is_write;
				// R10 write strobe released one clock early
				stb_d.wr_n     = ~is_write || (st_d == DHP_LAST);
			end
		end
	end

	// R12 R13 state, grant and strobes registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= DHP_IDLE;
			stb_q <= dhp_pkg::STROBE_IDLE;
			ws_q <= 4'h0;
		end else begin
			st_q  <= st_d;
			stb_q <= stb_d;
			ws_q  <= (st_d == DHP_WAITS && st_q != DHP_WAITS) ? ws_cfg :
				(st_q == DHP_WAITS ? ws_q - 4'h1 : 4'h0);
		end
	end

	// R13 one transfer per request: rearm after request rises
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_armed_q <= 1'b1;
		end else if (st_q == DHP_IDLE && start) begin
			req_armed_q <= 1'b0;
		end else if (!req_low && st_q != DHP_ACCESS) begin
			req_armed_q <= 1'b1;
		end
	end

	// data drive, ack, address and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_q  <= '0;
			oe_q    <= 1'b0;
			ack_q   <= 1'b0;
			addr_q  <= dhp_pkg::ADDR_RST;
			count_q <= 32'h0;
			err_q   <= 1'b0;
		end else begin
			if (st_q == DHP_IDLE && start && is_write) dout_q <= fout_data;
			oe_q  <= is_write && (st_d != DHP_IDLE) && (st_d != DHP_GAP);
			ack_q <= (st_d == DHP_LAST) && (paced || ext_hs);
			if (reg_wr && sel_addr) addr_q <= reg_wdata;
			else if (last_out && addr_inc) addr_q <= addr_q + 32'h1;
			if (reg_wr && sel_count) count_q <= 32'h0;
			else if (last_out) count_q <= count_q + 32'h1;
			// overflow on data port write when full; set wins over clear
			if (reg_wr && sel_data && is_write && !fin_ready) err_q <= 1'b1;
			else if (reg_wr && sel_stat) err_q <= 1'b0;
		end
	end

	// config registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= dhp_pkg::CTRL_RST;
			wait_q <= dhp_pkg::WAIT_RST;
		end else begin
			if (reg_wr && sel_ctrl) ctrl_q <= reg_wdata & 32'h0000_0077;
			if (reg_wr && sel_wait) wait_q <= reg_wdata & 32'h0000_003f;
		end
	end

	// read mux
	wire [31:0] rmux =
		sel_ctrl  ? ctrl_q :
		sel_wait  ? wait_q :
		sel_addr  ? addr_q :
		sel_stat  ? status_w :
		sel_data  ? 32'(fout_data) :
		sel_count ? count_q : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd ? rmux : 32'h0;
		end
	end

	assign reg_rdata           = rdata_q;
	assign dma_grant_n         = stb_q.dma_grant_n_n;
	assign rd_n                = stb_q.rd_n;
	assign wr_n                = stb_q.wr_n;
	assign sync_write_select_n = stb_q.sw_n;
	assign page                = stb_q.page;
	assign memory_select_n     = stb_q.ms_n;
	assign ack                 = ack_q;
	assign addr                = addr_q;
	assign data_out            = dout_q;
	assign data_oe             = oe_q;

	// R4 grant stays high in paced master
	a_grant_low_paced: assert property (@(posedge clk) disable iff (!rst_n)
		paced && $past(paced) |-> dma_grant_n) else $error("grant low in paced mode"); // R4
	// R1 start needs request
	a_start_req: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == DHP_ACCESS && $past(st_q) == DHP_IDLE |-> $past(req_low))
		else $error("transfer without request"); // R1
	// R10 write strobe before grant
	a_wr_before_grant: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wr_n) && !paced |-> !dma_grant_n ##1 dma_grant_n)
		else $error("write strobe not released a clock before grant"); // R10
	// R11 read strobe rise
	a_rd_with_grant: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(dma_grant_n) && $past(!rd_n) |-> rd_n) else $error("read strobe outlives grant"); // R11
	// R9 gap after grant high
	a_hold_gap: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(dma_grant_n) && hold_cfg |-> dma_grant_n[*2]) else $error("missing hold clock"); // R9
	// R5 stretch holds grant while request low
	a_stretch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == DHP_STRETCH && req_low |=> st_q == DHP_STRETCH) else $error("stretch ended early"); // R5
	// R8 one wait state adds a clock
	a_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == DHP_ACCESS && ws_cfg == 4'h1 && $stable(wait_q) |=> st_q == DHP_WAITS)
		else $error("wait state skipped"); // R8
	// R13 grant high in the clock after the last access cycle
	a_one_per_req: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == DHP_LAST |=> dma_grant_n)
		else $error("back to back grant"); // R13
endmodule
`default_nettype wire

// >>> tb/dhp_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_ext_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [3:0]  extra,
	input  wire logic [31:0] rd_word,
	input  wire logic        dma_grant_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [31:0] data_out,
	output logic             dma_request_n,
	output logic [31:0]      data_in,
	output logic [31:0]      last_wdata
);
	logic [4:0]  cnt_q;
	logic [31:0] junk_q;

	// request low one cycle, longer to stretch the access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 5'h0;
			dma_request_n <= 1'b1;
		end else if (start) begin
			cnt_q <= {1'b0, extra};
			dma_request_n <= 1'b0;
		end else if (cnt_q != 5'h0) begin
			cnt_q <= cnt_q - 5'h1;
		end else begin
			dma_request_n <= 1'b1;
		end
	end

	// data only while granted or read strobe low, changing junk otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			junk_q     <= 32'h0;
			last_wdata <= 32'h0;
		end else begin
			junk_q <= ~junk_q ^ 32'h5a5a_0f0f;
			// grant low latches in handshake mode, write strobe otherwise
			if (!wr_n || !dma_grant_n)
				last_wdata <= data_out;
		end
	end
	assign data_in = (!dma_grant_n || !rd_n) ? rd_word : junk_q;
endmodule
`default_nettype wire

// >>> tb/dhp_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_port_tb_top;
	logic        clk, rst_n, reg_wr, reg_rd, start;
	logic [3:0]  reg_addr, extra;
	logic [31:0] reg_wdata, reg_rdata, rd_word, last_wdata, rv;
	logic        dma_request_n, dma_grant_n, rd_n, wr_n, sws_n, page, ack, data_oe;
	logic [3:0]  memory_select_n;
	logic [31:0] addr, data_in, data_out;
	int          failures, compares, xfers, gl, sl, ac, oc;
	int          rows [8][6] = '{
		'{0, 0, 0, 0, 0, 2}, '{0, 1, 1, 0, 0, 3}, '{1, 0, 3, 0, 1, 5}, '{1, 1, 0, 2, 2, 2},
		'{1, 0, 0, 2, 0, 2}, '{2, 0, 2, 0, 0, 0}, '{2, 1, 0, 0, 1, 0}, '{3, 0, 0, 0, 0, 0}};

	dhp_port u_dhp_port (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_request_n(dma_request_n),
		.dma_grant_n(dma_grant_n), .rd_n(rd_n), .wr_n(wr_n), .sync_write_select_n(sws_n),
		.page(page), .memory_select_n(memory_select_n), .ack(ack), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	dhp_ext_model u_dhp_ext_model (.clk(clk), .rst_n(rst_n), .start(start), .extra(extra),
		.rd_word(rd_word), .dma_grant_n(dma_grant_n), .rd_n(rd_n), .wr_n(wr_n),
		.data_out(data_out), .dma_request_n(dma_request_n), .data_in(data_in),
		.last_wdata(last_wdata));

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// one request, then count grant, strobe and ack cycles
	task automatic do_xfer(input int st);
		@(posedge clk);
		extra <= 4'(st);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		gl = 0;
		sl = 0;
		ac = 0;
		oc = 0;
		repeat (30) begin
			@(negedge clk);
			oc += (data_oe === 1'b1);
			gl += (dma_grant_n === 1'b0);
			sl += (rd_n === 1'b0 || wr_n === 1'b0);
			ac += (ack === 1'b1);
		end
	endtask

	task automatic give_verdict;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog
	initial begin
		#2000000;
		failures++;
		give_verdict();
	end

	initial begin
		{reg_wr, reg_rd, start, reg_addr, extra, reg_wdata, rd_word} = '0;
		rst_n = 1'b0;
		failures = 0;
		compares = 0;
		xfers = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b0;
		#1 check(32'(dma_grant_n), 32'h1);
		rst_n <= 1'b1;
		reg_write(4'hf, 32'hffff_ffff);
		reg_read(dhp_pkg::CTRL_OFF, rv);
		check(rv, dhp_pkg::CTRL_RST);
		reg_read(dhp_pkg::WAIT_OFF, rv);
		check(rv, dhp_pkg::WAIT_RST);
		reg_read(dhp_pkg::ADDR_OFF, rv);
		check(rv, dhp_pkg::ADDR_RST);
		// table of transfers in every mode
		for (int i = 0; i < 8; i++) begin
			rd_word = 32'ha500_0000 + 32'(i);
			reg_write(dhp_pkg::CTRL_OFF, 32'(rows[i][0] | rows[i][1] << 2));
			reg_write(dhp_pkg::WAIT_OFF, 32'(rows[i][2] | rows[i][4] << 4));
			if (rows[i][1] == 1)
				reg_write(dhp_pkg::DATA_OFF, rd_word);
			do_xfer(rows[i][3]);
			check(32'(gl), 32'(rows[i][5] + (rows[i][0] < 2 ? rows[i][3] : 0)));
			if (rows[i][0] > 0)
				check(32'(sl), 32'(rows[i][0] == 3 ? 0 :
					2 + rows[i][2] + rows[i][3] - rows[i][1]));
			if (rows[i][0] > 0)
				check(32'(ac), 32'(rows[i][0] < 3));
			check(32'(oc), 32'(rows[i][0] < 3 && rows[i][1] == 1 ?
				3 + rows[i][2] + rows[i][3] : 0));
			xfers += (rows[i][0] < 3);
			reg_read(dhp_pkg::COUNT_OFF, rv);
			check(rv, 32'(xfers));
			if (rows[i][0] < 3 && rows[i][1] == 1)
				check(last_wdata, rd_word);
			if (rows[i][0] < 3 && rows[i][1] == 0) begin
				reg_read(dhp_pkg::DATA_OFF, rv);
				check(rv, rd_word);
			end
		end
		// fill the buffer past full with transfers off, then drain it
		reg_write(dhp_pkg::CTRL_OFF, 32'h7);
		for (int i = 0; i < 33; i++)
			reg_write(dhp_pkg::DATA_OFF, 32'hc000_0000 + 32'(i));
		reg_read(dhp_pkg::STATUS_OFF, rv);
		check({30'h0, rv[4], rv[0]}, 32'h2);
		reg_write(dhp_pkg::STATUS_OFF, 32'h0);
		reg_read(dhp_pkg::STATUS_OFF, rv);
		check(32'(rv[4]), 32'h0);
		reg_write(dhp_pkg::CTRL_OFF, 32'h3);
		for (int i = 0; i < 32; i++) begin
			reg_read(dhp_pkg::DATA_OFF, rv);
			check(rv, 32'hc000_0000 + 32'(i));
		end
		reg_read(dhp_pkg::STATUS_OFF, rv);
		check(32'(rv[1]), 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
